//--- src/bcdvs_ctrl.v
// register file and sequencing for converter scaling and soft-start
// assumes a single-cycle strobe master and synchronous scaling inputs
`timescale 1ns/1ps
`include "bcdvs_map.vh"

// Function
// - The scaling source picks off, register enable, input a or b.
// - Scaling codes step 12.5mV and clamp to 08h and 68h.
// - Converter three starts through three timed current-limit steps for soft-start codes other than 00.
// - Soft-start codes give none, 512us, 4.096ms, 32.768ms; reset 01.
// - The hysteretic current cap starts at code 01; 00 means 50mA.
// - Cap codes give 100/200/400mA and change only after key unlock.
// - Output cap range is written only during configuration load.
module bcdvs_ctrl
#(
	parameter [23:0] P_T512  = `BCDVS_T512_US * `BCDVS_CLK_MHZ,
	parameter [23:0] P_T4096 = `BCDVS_T4096_US * `BCDVS_CLK_MHZ,
	parameter [23:0] P_T32K  = `BCDVS_T32768_US * `BCDVS_CLK_MHZ
)
(
	input  wire        i_clock,
	input  wire        i_rst_n,
	input  wire        i_ce,
	input  wire [15:0] i_addr,
	input  wire [15:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire        i_cfg_load,
	input  wire        i_hw_scaling_input_a,
	input  wire        i_hw_scaling_input_b,
	input  wire        i_conv3_start,
	output reg  [15:0] o_rdata,
	output reg         o_conv1_scaling_active,
	output reg  [6:0]  o_conv1_target_code,
	output reg         o_conv2_scaling_active,
	output reg  [6:0]  o_conv2_target_code,
	output reg  [1:0]  o_conv3_limit_step,
	output reg         o_conv3_started,
	output reg  [1:0]  o_conv3_hysteretic_current_cap,
	output reg  [1:0]  o_conv3_output_cap_range
);

	// -----------------------------------------------------------
	// register storage
	// -----------------------------------------------------------
	reg [15:0] c1_dvs_q;
	reg [15:0] c2_ctl1_q;
	reg [15:0] c2_ctl2_q;
	reg [15:0] c2_on_q;
	reg [15:0] c2_slp_q;
	reg [15:0] c2_dvs_q;
	reg [15:0] c3_ctl1_q;
	reg        unlocked_q;

	wire       c1_act;
	wire [6:0] c1_code;
	wire       c2_act;
	wire [6:0] c2_code;

	// address match, shared by write decode and the cap-field guards
	function hit;
		input [15:0] a;
		input [15:0] b;
		hit = (a == b);
	endfunction

	// only bits in the mask move; the rest keep their stored value so
	// reserved bits always read back zero
	function [15:0] merge;
		input [15:0] old;
		input [15:0] nv;
		input [15:0] mask;
		merge = (old & ~mask) | (nv & mask);
	endfunction

	// -----------------------------------------------------------
	// register writes
	// -----------------------------------------------------------
	localparam [15:0] C3_RST = `BCDVS_RST_C3_CTL1;

	wire wr_c3 = i_wr && hit(i_addr, `BCDVS_ADDR_C3_CTL1);

	// the current cap and the capacitor range are guarded fields: they
	// stay out of the c3 mask and are written below only when allowed
	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			c1_dvs_q   <= `BCDVS_RST_ZERO;
			c2_ctl1_q  <= `BCDVS_RST_C2_CTL1;
			c2_ctl2_q  <= `BCDVS_RST_C2_CTL2;
			c2_on_q    <= `BCDVS_RST_ZERO;
			c2_slp_q   <= `BCDVS_RST_ZERO;
			c2_dvs_q   <= `BCDVS_RST_ZERO;
			c3_ctl1_q  <= `BCDVS_RST_C3_CTL1;
			unlocked_q <= 1'b0;
		end
		else if (i_ce && i_wr)
		begin
			if (hit(i_addr, `BCDVS_ADDR_C1_DVS))
				c1_dvs_q <= merge(c1_dvs_q, i_wdata, `BCDVS_MASK_DVS);
			if (hit(i_addr, `BCDVS_ADDR_C2_CTL1))
				c2_ctl1_q <= merge(c2_ctl1_q, i_wdata,
					`BCDVS_MASK_C2_CTL1);
			if (hit(i_addr, `BCDVS_ADDR_C2_CTL2))
				c2_ctl2_q <= merge(c2_ctl2_q, i_wdata,
					`BCDVS_MASK_C2_CTL2);
			if (hit(i_addr, `BCDVS_ADDR_C2_ON))
				c2_on_q <= merge(c2_on_q, i_wdata, `BCDVS_MASK_ON_SLP);
			if (hit(i_addr, `BCDVS_ADDR_C2_SLP))
				c2_slp_q <= merge(c2_slp_q, i_wdata, `BCDVS_MASK_ON_SLP);
			if (hit(i_addr, `BCDVS_ADDR_C2_DVS))
				c2_dvs_q <= merge(c2_dvs_q, i_wdata, `BCDVS_MASK_DVS);
			if (wr_c3)
			begin
				c3_ctl1_q <= merge(c3_ctl1_q, i_wdata,
					`BCDVS_MASK_C3_CTL1);
				if (unlocked_q)
					c3_ctl1_q[`BCDVS_LIM_HI:`BCDVS_LIM_LO] <=
						i_wdata[`BCDVS_LIM_HI:`BCDVS_LIM_LO];
				if (i_cfg_load)
					c3_ctl1_q[`BCDVS_CAP_HI:`BCDVS_CAP_LO] <=
						i_wdata[`BCDVS_CAP_HI:`BCDVS_CAP_LO];
			end
			// any key write other than the key value locks again
			if (hit(i_addr, `BCDVS_ADDR_KEY))
				unlocked_q <= (i_wdata == `BCDVS_KEY_VALUE);
		end
	end

	// -----------------------------------------------------------
	// target selection per scaling converter
	// -----------------------------------------------------------
	// converter one has no ON code here, so its idle target is the floor
	// code; codes above 48h are not refused at 4MHz switching, that limit
	// is left to software
	localparam N_CONV = 2;
	localparam REG_W  = 16;
	localparam CODE_W = 7;
	localparam SRC_W  = `BCDVS_SRC_HI - `BCDVS_SRC_LO + 1;

	wire [N_CONV*REG_W-1:0]  dvs_pair = {c2_dvs_q, c1_dvs_q};
	wire [N_CONV*CODE_W-1:0] on_pair  = {c2_on_q[`BCDVS_VSEL_HI:0],
		`BCDVS_VSEL_MIN};
	wire [N_CONV-1:0]        act_pair;
	wire [N_CONV*CODE_W-1:0] code_pair;

	genvar g;
	generate
	for (g = 0; g < N_CONV; g = g + 1)
	begin : g_conv
		bcdvs_target u_tgt
		(
			.i_clock      (i_clock),
			.i_rst_n      (i_rst_n),
			.i_ce         (i_ce),
			.i_source     (dvs_pair[g*REG_W+`BCDVS_SRC_LO +: SRC_W]),
			.i_scale_code (dvs_pair[g*REG_W +: CODE_W]),
			.i_on_code    (on_pair[g*CODE_W +: CODE_W]),
			.i_hw_a       (i_hw_scaling_input_a),
			.i_hw_b       (i_hw_scaling_input_b),
			.o_active     (act_pair[g]),
			.o_code       (code_pair[g*CODE_W +: CODE_W])
		);
	end
	endgenerate

	assign c1_act  = act_pair[0];
	assign c1_code = code_pair[CODE_W-1:0];
	assign c2_act  = act_pair[1];
	assign c2_code = code_pair[N_CONV*CODE_W-1:CODE_W];

	// -----------------------------------------------------------
	// converter three soft-start sequencer
	// -----------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_STEP = 3'h2;
	localparam [2:0] ST_DONE = 3'h4;

	reg [2:0]  state_q;
	reg [23:0] tick_q;
	reg [23:0] len;
	reg [1:0]  step_q;
	wire [1:0] ss = c3_ctl1_q[`BCDVS_SS_HI:`BCDVS_SS_LO];

	// durations are clock-cycle counts so a bench can shrink them; code
	// 00 never reaches the counter, it goes straight to done

	always @*
	begin
		case (ss)
			`BCDVS_SS_512US: len = P_T512;
			`BCDVS_SS_4MS:   len = P_T4096;
			default:         len = P_T32K;
		endcase
	end

	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q <= ST_IDLE;
			tick_q  <= 24'h000000;
			step_q  <= 2'h0;
		end
		else if (i_ce)
		begin
			case (state_q)
				ST_IDLE:
					if (i_conv3_start)
					begin
						tick_q <= 24'h000000;
						if (ss == `BCDVS_SS_NONE)
							state_q <= ST_DONE;
						else
						begin
							step_q  <= 2'h1;
							state_q <= ST_STEP;
						end
					end
				// dropping the enable mid-step returns to idle, so a retry
				// always restarts at the first, lowest limit
				ST_STEP:
					if (!i_conv3_start)
					begin
						state_q <= ST_IDLE;
						step_q  <= 2'h0;
					end
					else if (tick_q == len - 24'h000001)
					begin
						tick_q <= 24'h000000;
						if (step_q == `BCDVS_SS_STEPS)
						begin
							step_q  <= 2'h0;
							state_q <= ST_DONE;
						end
						else
							step_q <= step_q + 2'h1;
					end
					else
						tick_q <= tick_q + 24'h000001;
				ST_DONE:
					if (!i_conv3_start)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// -----------------------------------------------------------
	// read port and registered outputs
	// -----------------------------------------------------------
	// o_rdata is zero outside the cycle after a read strobe, so a late
	// sample sees zero rather than a stale word
	reg [15:0] rd_mux;

	always @*
	begin
		case (i_addr)
			`BCDVS_ADDR_C1_DVS:  rd_mux = c1_dvs_q;
			`BCDVS_ADDR_C2_CTL1: rd_mux = c2_ctl1_q;
			`BCDVS_ADDR_C2_CTL2: rd_mux = c2_ctl2_q;
			`BCDVS_ADDR_C2_ON:   rd_mux = c2_on_q;
			`BCDVS_ADDR_C2_SLP:  rd_mux = c2_slp_q;
			`BCDVS_ADDR_C2_DVS:  rd_mux = c2_dvs_q;
			`BCDVS_ADDR_C3_CTL1: rd_mux = c3_ctl1_q;
			`BCDVS_ADDR_KEY:     rd_mux = {15'h0000, unlocked_q};
			`BCDVS_ADDR_STATUS:  rd_mux = {9'h000, state_q == ST_DONE,
				step_q, c2_act, c1_act, 2'h0};
			default:             rd_mux = `BCDVS_RST_ZERO;
		endcase
	end

	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rdata                        <= `BCDVS_RST_ZERO;
			o_conv1_scaling_active         <= 1'b0;
			o_conv1_target_code            <= `BCDVS_VSEL_MIN;
			o_conv2_scaling_active         <= 1'b0;
			o_conv2_target_code            <= `BCDVS_VSEL_MIN;
			o_conv3_limit_step             <= 2'h0;
			o_conv3_started                <= 1'b0;
			o_conv3_hysteretic_current_cap <=
				C3_RST[`BCDVS_LIM_HI:`BCDVS_LIM_LO];
			o_conv3_output_cap_range       <=
				C3_RST[`BCDVS_CAP_HI:`BCDVS_CAP_LO];
		end
		else if (i_ce)
		begin
			o_rdata                <= i_rd ? rd_mux : `BCDVS_RST_ZERO;
			o_conv1_scaling_active <= c1_act;
			o_conv1_target_code    <= c1_code;
			o_conv2_scaling_active <= c2_act;
			o_conv2_target_code    <= c2_code;
			o_conv3_limit_step     <= step_q;
			o_conv3_started        <= (state_q == ST_DONE);
			o_conv3_hysteretic_current_cap <=
				c3_ctl1_q[`BCDVS_LIM_HI:`BCDVS_LIM_LO];
			o_conv3_output_cap_range <=
				c3_ctl1_q[`BCDVS_CAP_HI:`BCDVS_CAP_LO];
		end
	end

endmodule

//--- inc/bcdvs_map.vh
// register offsets, field positions, reset values and timing counts
// for the buck converter scaling and soft-start control block
`ifndef BCDVS_MAP_VH
`define BCDVS_MAP_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define BCDVS_ADDR_C1_DVS   16'h405a
`define BCDVS_ADDR_C2_CTL1  16'h405b
`define BCDVS_ADDR_C2_CTL2  16'h405c
`define BCDVS_ADDR_C2_ON    16'h405d
`define BCDVS_ADDR_C2_SLP   16'h405e
`define BCDVS_ADDR_C2_DVS   16'h405f
`define BCDVS_ADDR_C3_CTL1  16'h4060
`define BCDVS_ADDR_KEY      16'h4070
`define BCDVS_ADDR_STATUS   16'h4071

// ---------------------------------------------------------------
// writable masks and reset values
// ---------------------------------------------------------------
`define BCDVS_MASK_DVS      16'h187f
`define BCDVS_MASK_C2_CTL1  16'hd3b3
`define BCDVS_MASK_C2_CTL2  16'hdf71
`define BCDVS_MASK_ON_SLP   16'he37f
`define BCDVS_MASK_C3_CTL1  16'h10b0
`define BCDVS_RST_C2_CTL1   16'h8000
`define BCDVS_RST_C2_CTL2   16'h0300
`define BCDVS_RST_C3_CTL1   16'h0014
`define BCDVS_RST_ZERO      16'h0000

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BCDVS_SRC_HI        12
`define BCDVS_SRC_LO        11
`define BCDVS_VSEL_HI       6
`define BCDVS_SS_HI         5
`define BCDVS_SS_LO         4
`define BCDVS_LIM_HI        3
`define BCDVS_LIM_LO        2
`define BCDVS_CAP_HI        1
`define BCDVS_CAP_LO        0

// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define BCDVS_SRC_OFF       2'h0
`define BCDVS_SRC_REG       2'h1
`define BCDVS_SRC_HWA       2'h2
`define BCDVS_SRC_HWB       2'h3
`define BCDVS_VSEL_MIN      7'h08
`define BCDVS_VSEL_MAX      7'h68
`define BCDVS_SS_NONE       2'h0
`define BCDVS_SS_512US      2'h1
`define BCDVS_SS_4MS        2'h2
`define BCDVS_KEY_VALUE     16'h9716
`define BCDVS_SS_STEPS      2'h3

// ---------------------------------------------------------------
// timing, 40 MHz clock; step figures in microseconds
// ---------------------------------------------------------------
`define BCDVS_CLK_MHZ       40
`define BCDVS_T512_US       512
`define BCDVS_T4096_US      4096
`define BCDVS_T32768_US     32768

`endif

//--- src/bcdvs_target.v
// one converter's effective voltage target selection and clamping
// assumes hardware scaling inputs already synchronous to i_clock
`timescale 1ns/1ps
`include "bcdvs_map.vh"

module bcdvs_target
(
	input  wire       i_clock,
	input  wire       i_rst_n,
	input  wire       i_ce,
	input  wire [1:0] i_source,
	input  wire [6:0] i_scale_code,
	input  wire [6:0] i_on_code,
	input  wire       i_hw_a,
	input  wire       i_hw_b,
	output reg        o_active,
	output reg  [6:0] o_code
);

	reg       act;
	reg [6:0] raw;

	always @*
	begin
		case (i_source)
			`BCDVS_SRC_OFF: act = 1'b0;
			`BCDVS_SRC_REG: act = 1'b1;
			`BCDVS_SRC_HWA: act = i_hw_a;
			default:        act = i_hw_b;
		endcase
		raw = act ? i_scale_code : i_on_code;
		// codes below the floor or above the ceiling saturate
		if (raw < `BCDVS_VSEL_MIN)
			raw = `BCDVS_VSEL_MIN;
		else if (raw > `BCDVS_VSEL_MAX)
			raw = `BCDVS_VSEL_MAX;
	end

	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_active <= 1'b0;
			o_code   <= `BCDVS_VSEL_MIN;
		end
		else if (i_ce)
		begin
			o_active <= act;
			o_code   <= raw;
		end
	end

endmodule

//--- test/bcdvs_properties.sv
// checker for the converter scaling and soft-start control block
// sees only ports of bcdvs_ctrl; bound at the foot of this file
`timescale 1ns/1ps
module bcdvs_chk
(
	input wire        i_clock,
	input wire        i_rst_n,
	input wire        i_wr,
	input wire        i_cfg_load,
	input wire        i_conv3_start,
	input wire        o_conv1_scaling_active,
	input wire [6:0]  o_conv1_target_code,
	input wire [6:0]  o_conv2_target_code,
	input wire [1:0]  o_conv3_limit_step,
	input wire        o_conv3_started,
	input wire [1:0]  o_conv3_hysteretic_current_cap,
	input wire [1:0]  o_conv3_output_cap_range
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	// -----------------------------------------------
	// recent causes; outputs trail the write by 2-3 cycles
	// -----------------------------------------------
	sequence recent_wr_s;
		$past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3);
	endsequence
	sequence recent_cfg_s;
		$past(i_cfg_load) || $past(i_cfg_load, 2) || $past(i_cfg_load, 3);
	endsequence
	conv1_range_a: assert property (o_conv1_target_code >= 7'h08 &&
		o_conv1_target_code <= 7'h68) else $error("conv1 code out of range");
	conv2_range_a: assert property (o_conv2_target_code
		inside {[7'h08:7'h68]}) else $error("conv2 code out of range");
	inactive_code_a: assert property ($stable(o_conv1_scaling_active) &&
		!o_conv1_scaling_active |-> o_conv1_target_code == 7'h08)
		else $error("idle conv1 target not minimum");
	step_order_a: assert property ($changed(o_conv3_limit_step) |->
		o_conv3_limit_step == $past(o_conv3_limit_step) + 2'h1 ||
		o_conv3_limit_step == 2'h0) else $error("soft-start step skipped");
	started_idle_a: assert property (o_conv3_started |->
		o_conv3_limit_step == 2'h0) else $error("started while stepping");
	abort_idle_a: assert property (!i_conv3_start [*3] |->
		o_conv3_limit_step == 2'h0 && !o_conv3_started)
		else $error("soft-start not idle after stop");
	cap_write_a: assert property ($changed(o_conv3_hysteretic_current_cap)
		|-> recent_wr_s) else $error("cap changed without write");
	range_load_a: assert property ($changed(o_conv3_output_cap_range)
		|-> recent_cfg_s) else $error("cap range changed outside load");
endmodule

bind bcdvs_ctrl bcdvs_chk i_chk
(
	.i_clock                        (i_clock),
	.i_rst_n                        (i_rst_n),
	.i_wr                           (i_wr),
	.i_cfg_load                     (i_cfg_load),
	.i_conv3_start                  (i_conv3_start),
	.o_conv1_scaling_active         (o_conv1_scaling_active),
	.o_conv1_target_code            (o_conv1_target_code),
	.o_conv2_target_code            (o_conv2_target_code),
	.o_conv3_limit_step             (o_conv3_limit_step),
	.o_conv3_started                (o_conv3_started),
	.o_conv3_hysteretic_current_cap (o_conv3_hysteretic_current_cap),
	.o_conv3_output_cap_range       (o_conv3_output_cap_range)
);

//--- test/bcdvs_host.sv
// host software and scaling pins facing the control block
// assumes the block answers reads one cycle after the strobe
`timescale 1ns/1ps
module bcdvs_host
(
	input  wire        i_clock,
	input  wire [15:0] i_rdata,
	output reg  [15:0] o_addr,
	output reg  [15:0] o_wdata,
	output reg         o_wr,
	output reg         o_rd,
	output reg         o_hw_a,
	output reg         o_hw_b,
	output reg         o_cfg_load
);
	initial
	begin
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_hw_a = 1'b0;
		o_hw_b = 1'b0;
		o_cfg_load = 1'b0;
	end
	// this host never selects 4MHz switching, so codes past 48h stay legal
	task wr(input [15:0] a, input [15:0] d);
	begin
		@(posedge i_clock);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clock);
		o_wr <= 1'b0;
	end
	endtask
	task rd(input [15:0] a, output [15:0] d);
	begin
		@(posedge i_clock);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clock);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	end
	endtask
	task pins(input a, input b, input c);
	begin
		@(posedge i_clock);
		o_hw_a <= a;
		o_hw_b <= b;
		o_cfg_load <= c;
	end
	endtask
endmodule

//--- test/testbench.sv
// self-checking bench for bcdvs_ctrl with short soft-start counts
// assumes the host model drives the register bus and scaling pins
`timescale 1ns/1ps
`include "bcdvs_map.vh"
module testbench;
	reg         clk, rst_n, start, ce;
	wire [15:0] addr, wdata, rdata;
	wire        wr, rd, hwa, hwb, cfg, act1, act2, started;
	wire [6:0]  tc1, tc2;
	wire [1:0]  step, cap, rng;
	integer     miscompares, check_count, cycles, i, n;
	reg  [15:0] rv, dv;
	reg  [1:0]  src;
	reg  [6:0]  vs, onc;
	reg         a, b;
	localparam [34:0] CORNERS = {7'h7f, 7'h68, 7'h09, 7'h08, 7'h00};
	localparam [23:0] T512 = 24'd4;
	localparam [23:0] T4096 = 24'd8;
	localparam [23:0] T32K = 24'd16;
	bcdvs_host i_host (.i_clock(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_hw_a(hwa), .o_hw_b(hwb),
		.o_cfg_load(cfg));
	bcdvs_ctrl #(.P_T512(T512), .P_T4096(T4096), .P_T32K(T32K)) i_dut
	(.i_clock(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_cfg_load(cfg),
		.i_hw_scaling_input_a(hwa), .i_hw_scaling_input_b(hwb),
		.i_conv3_start(start), .o_rdata(rdata),
		.o_conv1_scaling_active(act1), .o_conv1_target_code(tc1),
		.o_conv2_scaling_active(act2), .o_conv2_target_code(tc2),
		.o_conv3_limit_step(step), .o_conv3_started(started),
		.o_conv3_hysteretic_current_cap(cap),
		.o_conv3_output_cap_range(rng));
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 5000)
		begin
			miscompares = miscompares + 1;
			complete_run;
		end
	end
	function [6:0] clamp(input [6:0] v);
		clamp = v < 7'h08 ? 7'h08 : (v > 7'h68 ? 7'h68 : v);
	endfunction
	function act(input [1:0] s, input x, input y);
		act = s == 2'h1 || (s == 2'h2 && x) || (s == 2'h3 && y);
	endfunction
	// three timed steps per start for codes 1 to 3, each lasting the chosen duration
	function [15:0] steps(input [1:0] c);
		case (c)
			2'h0: steps = 16'h0000;
			2'h1: steps = 16'd3 * T512[15:0];
			2'h2: steps = 16'd3 * T4096[15:0];
			default: steps = 16'd3 * T32K[15:0];
		endcase
	endfunction
	task check(input [15:0] seen, input [15:0] exp);
	begin
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task complete_run;
	begin
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		start = 1'b0;
		ce = 1'b1;
		cycles = 0;
		miscompares = 0;
		check_count = 0;
		n = $urandom(6702);
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1 check(cap, 16'h1);
		check(tc1, 16'h8);
		i_host.rd(`BCDVS_ADDR_C3_CTL1, rv);
		check(rv, `BCDVS_RST_C3_CTL1);
		i_host.rd(16'h4080, rv);
		check(rv, 16'h0);
		// -----------------------------------------------
		// scaling source, pins and code saturation
		// -----------------------------------------------
		for (i = 0; i < 16; i = i + 1)
		begin
			src = i < 8 ? i[1:0] : $urandom;
			vs = i < 5 ? CORNERS[i*7 +: 7] : $urandom;
			onc = $urandom;
			a = $urandom;
			b = $urandom;
			dv = {3'h0, src, 4'h0, vs};
			i_host.wr(`BCDVS_ADDR_C1_DVS, dv);
			i_host.wr(`BCDVS_ADDR_C2_ON, {9'h0, onc});
			i_host.wr(`BCDVS_ADDR_C2_DVS, {3'h0, ~src, 4'h0, vs});
			i_host.pins(a, b, 1'b0);
			repeat (4) @(posedge clk);
			check(act1, act(src, a, b));
			check(tc1, act(src, a, b) ? clamp(vs) : 7'h08);
			check(act2, act(~src, a, b));
			check(tc2, act(~src, a, b) ? clamp(vs) : clamp(onc));
			i_host.rd(`BCDVS_ADDR_C1_DVS, rv);
			check(rv, dv);
		end
		// a write while the clock enable is low must not land
		@(posedge clk);
		ce <= 1'b0;
		i_host.wr(`BCDVS_ADDR_C1_DVS, ~dv);
		ce <= 1'b1;
		i_host.rd(`BCDVS_ADDR_C1_DVS, rv);
		check(rv, dv);
		// -----------------------------------------------
		// key-protected cap and load-only range
		// -----------------------------------------------
		i_host.wr(`BCDVS_ADDR_C3_CTL1, 16'h001c);
		repeat (4) @(posedge clk);
		check(cap, 16'h1);
		i_host.wr(`BCDVS_ADDR_KEY, `BCDVS_KEY_VALUE);
		i_host.rd(`BCDVS_ADDR_KEY, rv);
		check(rv, 16'h1);
		i_host.wr(`BCDVS_ADDR_C3_CTL1, 16'h0018);
		repeat (4) @(posedge clk);
		check(cap, 16'h2);
		i_host.wr(`BCDVS_ADDR_C3_CTL1, 16'h0013);
		repeat (4) @(posedge clk);
		check(cap, 16'h0);
		check(rng, 16'h0);
		i_host.pins(1'b0, 1'b0, 1'b1);
		i_host.wr(`BCDVS_ADDR_C3_CTL1, 16'h0012);
		i_host.pins(1'b0, 1'b0, 1'b0);
		repeat (4) @(posedge clk);
		check(rng, 16'h2);
		// -----------------------------------------------
		// soft-start step counts for every code
		// -----------------------------------------------
		for (i = 0; i < 4; i = i + 1)
		begin
			i_host.wr(`BCDVS_ADDR_C3_CTL1, {10'h0, i[1:0], 4'h8});
			n = 0;
			@(posedge clk);
			start <= 1'b1;
			repeat (60)
			begin
				@(posedge clk);
				#1 if (step !== 2'h0) n = n + 1;
			end
			check(n[15:0], steps(i[1:0]));
			check(started, 16'h1);
			i_host.rd(`BCDVS_ADDR_STATUS, rv);
			dv = {9'h0, 1'b1, 2'h0, act(~src, 1'b0, 1'b0),
				act(src, 1'b0, 1'b0), 2'h0};
			check(rv, dv);
			@(posedge clk);
			start <= 1'b0;
			repeat (4) @(posedge clk);
		end
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 check(cap, 16'h1);
		check(rng, 16'h0);
		i_host.rd(`BCDVS_ADDR_KEY, rv);
		check(rv, 16'h0);
		complete_run;
	end
endmodule
